// ---- include/drive_input_pkg.sv ----
package drive_input_pkg;
    // scan timing
    localparam int unsigned CLK_FREQ_HZ = 40_000_000;
    localparam int unsigned SCAN_SHORT_MS = 5;
    localparam int unsigned SCAN_LONG_MS = 10;
    localparam int unsigned SCAN_SHORT_CYC =
        CLK_FREQ_HZ / 1000 * SCAN_SHORT_MS;
    localparam int unsigned SCAN_LONG_CYC = CLK_FREQ_HZ / 1000 * SCAN_LONG_MS;
    localparam int unsigned SCAN_CNT_W = 19;

    // terminal count and code width
    localparam int unsigned NUM_TERM = 4;
    localparam int unsigned FUNC_W = 6;
    localparam int unsigned AN_W = 12;

    // function codes
    localparam logic [5:0] FN_THREE_WIRE_DIR = 6'h00;
    localparam logic [5:0] FN_TWO_WIRE_STOP = 6'h01;
    localparam logic [5:0] FN_SPEED_BIT1 = 6'h02;
    localparam logic [5:0] FN_SPEED_BIT4 = 6'h05;
    localparam logic [5:0] FN_JOG = 6'h06;
    localparam logic [5:0] FN_ACC_DEC_SWITCH = 6'h07;
    localparam logic [5:0] FN_BASEBLOCK_NO = 6'h08;
    localparam logic [5:0] FN_BASEBLOCK_NC = 6'h09;
    localparam logic [5:0] FN_SPEED_SEARCH1 = 6'h15;
    localparam logic [5:0] FN_SPEED_SEARCH2 = 6'h16;
    localparam logic [5:0] FN_MAX = 6'h21;

    // setting ranges
    localparam logic [1:0] RESPONSE_MAX = 2'h3;
    localparam logic [2:0] OVERLOAD_MAX = 3'h4;
    localparam logic [1:0] SOURCE_MAX = 2'h3;

    // source encodings
    localparam logic [1:0] SRC_VOLTAGE = 2'h0;
    localparam logic [1:0] SRC_CURRENT = 2'h1;
    localparam logic [1:0] SRC_SUM = 2'h2;
    localparam logic [1:0] SRC_DIFF = 2'h3;

    // brake current limit, percent of rated
    localparam int unsigned HOLD_BRAKE_PCT = 20;

    // values after reset
    localparam logic [1:0] RESPONSE_RST = 2'h0;
    localparam logic [2:0] OVERLOAD_RST = 3'h1;
    localparam logic [1:0] SOURCE_RST = 2'h0;
    localparam logic [5:0] TERM5_RST = 6'h02;
    localparam logic [5:0] TERM6_RST = 6'h03;
    localparam logic [5:0] TERM7_RST = 6'h06;
    localparam logic [5:0] TERM8_RST = 6'h08;

    typedef enum logic [3:0] {
        ACT_DECEL1 = 4'b0001,
        ACT_COAST = 4'b0010,
        ACT_DECEL2 = 4'b0100,
        ACT_CONTINUE = 4'b1000
    } fault_action_t;
endpackage : drive_input_pkg

// ---- core/input_sync.sv ----
`timescale 1ns/1ps
// three-stage synchroniser; change taken once stages two and three agree
module input_sync (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic SRST_I,
    // pin and result
    input wire logic async_i,
    output logic sync_o
);
    logic meta_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            meta_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            meta_reg <= async_i;
            s2_reg <= meta_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            sync_o <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            sync_o <= s3_reg;
        end
    end
endmodule : input_sync

// ---- core/scan_timer.sv ----
`timescale 1ns/1ps
// one-cycle tick at the selected scan period
module scan_timer (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic SRST_I,
    // control and tick
    input wire logic long_period_i,
    output logic tick_o
);
    localparam logic [18:0] SHORT_LAST =
        19'(drive_input_pkg::SCAN_SHORT_CYC - 1);
    localparam logic [18:0] LONG_LAST =
        19'(drive_input_pkg::SCAN_LONG_CYC - 1);

    logic [18:0] count_reg;
    logic [18:0] last;

    assign last = long_period_i ? LONG_LAST : SHORT_LAST;

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            count_reg <= 19'h0_0000;
            tick_o <= 1'b0;
        end else if (count_reg >= last) begin
            count_reg <= 19'h0_0000;
            tick_o <= 1'b1;
        end else begin
            count_reg <= count_reg + 19'h0_0001;
            tick_o <= 1'b0;
        end
    end
endmodule : scan_timer

// ---- core/drive_input_fault_select.sv ----
`timescale 1ns/1ps
// Overview of operation
// - terminal run and command, 0 V, forward run: hold by DC braking
// - holding brake current limited to one fifth of rated current
// - fault polarity 0 normally open, 1 normally closed
// - fault window 0 always, 1 only while running
// - fault response: decel first, coast, decel second, keep running
// - overload mode 0 off, 1 to 4 select thermal curve
// - thermal accumulator cleared at power off
// - frequency source: voltage, current loop, sum, difference
// - unipolar negative difference clamps reference to zero
// - bipolar voltage input maps minus to reverse, plus to forward
// - bipolar sources 0, 2, 3 take direction from command sign
// - four terminals each have a code from one shared table
// - code 00 three-wire direction, code 01 two-wire stop
// - codes 02 to 05 are multi-speed select bits 1 to 4
// - code 06 on selects jog frequency
// - code 07 off first ramp pair, on second pair
// - code 08 on blocks output stage
// - code 09 off blocks output stage
// - setting error: codes not increasing or both speed searches set
// - scan period 0 is 5 ms, 1 is 10 ms
module drive_input_fault_select (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic SRST_I,
    // settings
    input wire logic SETTINGS_LOAD_I,
    input wire logic ZERO_SPEED_BRAKE_ENABLE_I,
    input wire logic EXT_FAULT_POLARITY_I,
    input wire logic EXT_FAULT_WINDOW_I,
    input wire logic [1:0] EXT_FAULT_RESPONSE_I,
    input wire logic [2:0] MOTOR_OVERLOAD_MODE_I,
    input wire logic [1:0] FREQ_SOURCE_SELECT_I,
    input wire logic [5:0] TERMINAL5_FUNCTION_I,
    input wire logic [5:0] TERMINAL6_FUNCTION_I,
    input wire logic [5:0] TERMINAL7_FUNCTION_I,
    input wire logic [5:0] TERMINAL8_FUNCTION_I,
    input wire logic RUN_SOURCE_TERMINAL_I,
    input wire logic FREQ_COMMAND_TERMINAL_I,
    input wire logic BIPOLAR_INPUT_ENABLE_I,
    input wire logic INPUT_SCAN_PERIOD_I,
    input wire logic [7:0] DC_BRAKE_CURRENT_I,
    // field contacts
    input wire logic [3:0] TERMINAL_I,
    input wire logic EXT_FAULT_I,
    input wire logic FORWARD_RUN_I,
    input wire logic REVERSE_CMD_I,
    // drive state and analog
    input wire logic RUNNING_I,
    input wire logic POWER_OFF_I,
    input wire logic THERMAL_ADD_I,
    input wire logic signed [11:0] VOLTAGE_ANALOG_INPUT_I,
    input wire logic [11:0] CURRENT_LOOP_INPUT_I,
    // to sequencer
    output logic ZERO_SPEED_HOLD_O,
    output logic [7:0] HOLD_BRAKE_CURRENT_O,
    output logic EXT_FAULT_DETECTED_O,
    output logic [3:0] FAULT_ACTION_O,
    output logic OVERLOAD_ENABLE_O,
    output logic [1:0] OVERLOAD_CURVE_O,
    output logic [15:0] THERMAL_ACCUM_O,
    output logic [11:0] FREQ_REF_O,
    output logic FREQ_REVERSE_O,
    output logic THREE_WIRE_DIR_O,
    output logic TWO_WIRE_STOP_O,
    output logic [3:0] SPEED_SELECT_O,
    output logic JOG_SELECT_O,
    output logic SECOND_RAMP_O,
    output logic BASEBLOCK_O,
    output logic SETTING_ERROR_O
);
    localparam logic [7:0] HOLD_LIMIT =
        8'(drive_input_pkg::HOLD_BRAKE_PCT);

    logic response_ok;
    logic overload_ok;
    logic [1:0] fault_response_reg;
    logic [2:0] overload_mode_reg;
    logic [1:0] freq_source_reg;
    logic [5:0] term_func_reg [4];
    logic [5:0] term_func_in [4];
    logic [3:0] term_sync;
    logic [3:0] term_reg;
    logic fault_sync;
    logic fault_reg;
    logic fwd_sync;
    logic fwd_reg;
    logic scan_tick;
    logic fault_active;
    logic signed [13:0] v_ext;
    logic signed [13:0] i_ext;
    logic signed [13:0] freq_sum;
    logic [3:0] fn_three;
    logic [3:0] fn_stop;
    logic [3:0] fn_jog;
    logic [3:0] fn_ramp;
    logic [3:0] fn_bb;
    logic [3:0] speed_bits [4];
    logic [3:0] search1;
    logic [3:0] search2;
    logic order_bad;

    assign term_func_in[0] = TERMINAL5_FUNCTION_I;
    assign term_func_in[1] = TERMINAL6_FUNCTION_I;
    assign term_func_in[2] = TERMINAL7_FUNCTION_I;
    assign term_func_in[3] = TERMINAL8_FUNCTION_I;

    scan_timer u_scan (
        .CORE_CLK_I(CORE_CLK_I),
        .SRST_I(SRST_I),
        .long_period_i(INPUT_SCAN_PERIOD_I),
        .tick_o(scan_tick)
    );

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_term
            input_sync u_sync (
                .CORE_CLK_I(CORE_CLK_I),
                .SRST_I(SRST_I),
                .async_i(TERMINAL_I[g]),
                .sync_o(term_sync[g])
            );
        end
    endgenerate

    input_sync u_fault_sync (
        .CORE_CLK_I(CORE_CLK_I),
        .SRST_I(SRST_I),
        .async_i(EXT_FAULT_I),
        .sync_o(fault_sync)
    );

    input_sync u_fwd_sync (
        .CORE_CLK_I(CORE_CLK_I),
        .SRST_I(SRST_I),
        .async_i(FORWARD_RUN_I),
        .sync_o(fwd_sync)
    );

    // terminal, fault and forward contacts only move at scan instants
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            term_reg <= 4'h0;
            fault_reg <= 1'b0;
            fwd_reg <= 1'b0;
        end else if (scan_tick) begin
            term_reg <= term_sync;
            fault_reg <= fault_sync;
            fwd_reg <= fwd_sync;
        end
    end

    // settings latched on load, bad values dropped field by field
    assign response_ok = EXT_FAULT_RESPONSE_I <= drive_input_pkg::RESPONSE_MAX;
    assign overload_ok = MOTOR_OVERLOAD_MODE_I <=
        drive_input_pkg::OVERLOAD_MAX;

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            fault_response_reg <= drive_input_pkg::RESPONSE_RST;
            overload_mode_reg <= drive_input_pkg::OVERLOAD_RST;
            freq_source_reg <= drive_input_pkg::SOURCE_RST;
        end else if (SETTINGS_LOAD_I) begin
            if (response_ok) begin
                fault_response_reg <= EXT_FAULT_RESPONSE_I;
            end
            if (overload_ok) begin
                overload_mode_reg <= MOTOR_OVERLOAD_MODE_I;
            end
            freq_source_reg <= FREQ_SOURCE_SELECT_I;
        end
    end

    generate
        for (g = 0; g < 4; g++) begin : g_func
            logic [5:0] rst_code;
            assign rst_code = (g == 0) ? drive_input_pkg::TERM5_RST :
                (g == 1) ? drive_input_pkg::TERM6_RST :
                (g == 2) ? drive_input_pkg::TERM7_RST :
                drive_input_pkg::TERM8_RST;
            always_ff @(posedge CORE_CLK_I) begin
                if (SRST_I) begin
                    term_func_reg[g] <= rst_code;
                end else if (SETTINGS_LOAD_I &&
                        term_func_in[g] <= drive_input_pkg::FN_MAX) begin
                    term_func_reg[g] <= term_func_in[g];
                end
            end
            // per-terminal decode of the shared table
            assign fn_three[g] = term_reg[g] &&
                term_func_reg[g] == drive_input_pkg::FN_THREE_WIRE_DIR;
            assign fn_stop[g] = term_reg[g] &&
                term_func_reg[g] == drive_input_pkg::FN_TWO_WIRE_STOP;
            assign fn_jog[g] = term_reg[g] &&
                term_func_reg[g] == drive_input_pkg::FN_JOG;
            assign fn_ramp[g] = term_reg[g] &&
                term_func_reg[g] == drive_input_pkg::FN_ACC_DEC_SWITCH;
            // N.O. block when on, N.C. block when off
            assign fn_bb[g] = (term_func_reg[g] ==
                drive_input_pkg::FN_BASEBLOCK_NO && term_reg[g]) ||
                (term_func_reg[g] == drive_input_pkg::FN_BASEBLOCK_NC &&
                !term_reg[g]);
            for (genvar b = 0; b < 4; b++) begin : g_bit
                assign speed_bits[b][g] = term_reg[g] && term_func_reg[g] ==
                    6'(drive_input_pkg::FN_SPEED_BIT1 + 6'(b));
            end
            assign search1[g] =
                term_func_reg[g] == drive_input_pkg::FN_SPEED_SEARCH1;
            assign search2[g] =
                term_func_reg[g] == drive_input_pkg::FN_SPEED_SEARCH2;
        end
    endgenerate

    assign order_bad = !(term_func_reg[0] < term_func_reg[1] &&
        term_func_reg[1] < term_func_reg[2] &&
        term_func_reg[2] < term_func_reg[3]);

    // decoded terminal commands
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            THREE_WIRE_DIR_O <= 1'b0;
            TWO_WIRE_STOP_O <= 1'b0;
            SPEED_SELECT_O <= 4'h0;
            JOG_SELECT_O <= 1'b0;
            SECOND_RAMP_O <= 1'b0;
            BASEBLOCK_O <= 1'b0;
            SETTING_ERROR_O <= 1'b0;
        end else begin
            THREE_WIRE_DIR_O <= |fn_three;
            TWO_WIRE_STOP_O <= |fn_stop;
            SPEED_SELECT_O <= {|speed_bits[3], |speed_bits[2],
                |speed_bits[1], |speed_bits[0]};
            JOG_SELECT_O <= |fn_jog;
            SECOND_RAMP_O <= |fn_ramp;
            BASEBLOCK_O <= |fn_bb;
            SETTING_ERROR_O <= order_bad || (|search1 && |search2);
        end
    end

    // external fault: polarity then window
    assign fault_active = (fault_reg ^ EXT_FAULT_POLARITY_I) &&
        (!EXT_FAULT_WINDOW_I || RUNNING_I);

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            EXT_FAULT_DETECTED_O <= 1'b0;
            FAULT_ACTION_O <= 4'h0;
        end else begin
            EXT_FAULT_DETECTED_O <= fault_active;
            if (!fault_active) begin
                FAULT_ACTION_O <= 4'h0;
            end else begin
                unique case (fault_response_reg)
                    2'h0: FAULT_ACTION_O <= drive_input_pkg::ACT_DECEL1;
                    2'h1: FAULT_ACTION_O <= drive_input_pkg::ACT_COAST;
                    2'h2: FAULT_ACTION_O <= drive_input_pkg::ACT_DECEL2;
                    2'h3: FAULT_ACTION_O <= drive_input_pkg::ACT_CONTINUE;
                endcase
            end
        end
    end

    // overload select and thermal accumulator
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            OVERLOAD_ENABLE_O <= 1'b0;
            OVERLOAD_CURVE_O <= 2'h0;
        end else begin
            OVERLOAD_ENABLE_O <= overload_mode_reg != 3'h0;
            OVERLOAD_CURVE_O <= 2'(overload_mode_reg - 3'h1);
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I || POWER_OFF_I) begin
            THERMAL_ACCUM_O <= 16'h0000;
        end else if (THERMAL_ADD_I && OVERLOAD_ENABLE_O &&
                THERMAL_ACCUM_O != 16'hFFFF) begin
            THERMAL_ACCUM_O <= THERMAL_ACCUM_O + 16'h0001;
        end
    end

    // frequency command; current loop is offset-removed magnitude
    assign v_ext = BIPOLAR_INPUT_ENABLE_I ?
        14'(VOLTAGE_ANALOG_INPUT_I) :
        {2'b00, VOLTAGE_ANALOG_INPUT_I[11] ? 12'h000 :
        VOLTAGE_ANALOG_INPUT_I};
    assign i_ext = {2'b00, CURRENT_LOOP_INPUT_I};

    always_comb begin
        unique case (freq_source_reg)
            drive_input_pkg::SRC_VOLTAGE: freq_sum = v_ext;
            drive_input_pkg::SRC_CURRENT: freq_sum = i_ext;
            drive_input_pkg::SRC_SUM: freq_sum = v_ext + i_ext;
            drive_input_pkg::SRC_DIFF: freq_sum = v_ext - i_ext;
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            FREQ_REF_O <= 12'h000;
            FREQ_REVERSE_O <= 1'b0;
        end else if (freq_sum < 0 && !BIPOLAR_INPUT_ENABLE_I) begin
            FREQ_REF_O <= 12'h000;
            FREQ_REVERSE_O <= REVERSE_CMD_I;
        end else if (!BIPOLAR_INPUT_ENABLE_I ||
                freq_source_reg == drive_input_pkg::SRC_CURRENT) begin
            // magnitude saturates at full scale
            FREQ_REF_O <= (freq_sum > 14'sd4095) ? 12'hFFF : freq_sum[11:0];
            FREQ_REVERSE_O <= REVERSE_CMD_I;
        end else begin
            FREQ_REF_O <= (freq_sum < 0) ?
                ((-freq_sum > 14'sd4095) ? 12'hFFF : 12'(-freq_sum)) :
                ((freq_sum > 14'sd4095) ? 12'hFFF : freq_sum[11:0]);
            FREQ_REVERSE_O <= freq_sum < 0;
        end
    end

    // zero-speed holding brake
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            ZERO_SPEED_HOLD_O <= 1'b0;
            HOLD_BRAKE_CURRENT_O <= 8'h00;
        end else begin
            ZERO_SPEED_HOLD_O <= ZERO_SPEED_BRAKE_ENABLE_I &&
                RUN_SOURCE_TERMINAL_I && FREQ_COMMAND_TERMINAL_I &&
                fwd_reg && VOLTAGE_ANALOG_INPUT_I == 12'sh000;
            HOLD_BRAKE_CURRENT_O <= (DC_BRAKE_CURRENT_I > HOLD_LIMIT) ?
                HOLD_LIMIT : DC_BRAKE_CURRENT_I;
        end
    end
endmodule : drive_input_fault_select

// ---- sim/drive_input_monitor.sv ----
`timescale 1ns/1ps
module drive_input_monitor (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic SRST_I,
    // inputs
    input wire logic SETTINGS_LOAD_I,
    input wire logic EXT_FAULT_WINDOW_I,
    input wire logic [2:0] MOTOR_OVERLOAD_MODE_I,
    input wire logic [1:0] FREQ_SOURCE_SELECT_I,
    input wire logic FREQ_COMMAND_TERMINAL_I,
    input wire logic BIPOLAR_INPUT_ENABLE_I,
    input wire logic REVERSE_CMD_I,
    input wire logic RUNNING_I,
    input wire logic POWER_OFF_I,
    input wire logic signed [11:0] VOLTAGE_ANALOG_INPUT_I,
    input wire logic [11:0] CURRENT_LOOP_INPUT_I,
    // outputs
    input wire logic EXT_FAULT_DETECTED_O,
    input wire logic OVERLOAD_ENABLE_O,
    input wire logic [1:0] OVERLOAD_CURVE_O,
    input wire logic [15:0] THERMAL_ACCUM_O,
    input wire logic [11:0] FREQ_REF_O,
    input wire logic FREQ_REVERSE_O
);
    default clocking mon_cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (SRST_I);
    // mirrors the latched source; every 2-bit value is in range
    logic [1:0] src_reg;
    logic bip;
    logic uni;
    logic neg;
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            src_reg <= drive_input_pkg::SOURCE_RST;
        end else if (SETTINGS_LOAD_I) begin
            src_reg <= FREQ_SOURCE_SELECT_I;
        end
    end
    assign bip = BIPOLAR_INPUT_ENABLE_I && FREQ_COMMAND_TERMINAL_I;
    assign uni = !BIPOLAR_INPUT_ENABLE_I;
    assign neg = VOLTAGE_ANALOG_INPUT_I[11];
    sequence s_load_on;
        SETTINGS_LOAD_I && MOTOR_OVERLOAD_MODE_I inside {[3'h1:3'h4]};
    endsequence
    sequence s_load_bad;
        SETTINGS_LOAD_I && MOTOR_OVERLOAD_MODE_I > 3'h4 ##1 !SETTINGS_LOAD_I;
    endsequence
    a_overload_curve: assert property (
        s_load_on |-> ##2 OVERLOAD_ENABLE_O &&
        3'(OVERLOAD_CURVE_O) + 3'h1 == $past(MOTOR_OVERLOAD_MODE_I, 2))
        else $error("overload curve wrong");
    a_overload_keep: assert property (
        s_load_bad |-> ##1 $stable({OVERLOAD_ENABLE_O, OVERLOAD_CURVE_O}))
        else $error("refused mode changed overload");
    a_fault_window: assert property (
        (EXT_FAULT_WINDOW_I && !RUNNING_I) [*2] |-> !EXT_FAULT_DETECTED_O)
        else $error("fault seen while stopped");
    a_thermal_clear: assert property (
        POWER_OFF_I |=> THERMAL_ACCUM_O == 16'h0000)
        else $error("thermal not cleared");
    a_volt_ref: assert property (
        uni && src_reg == 2'h0 && !neg |=>
        FREQ_REF_O == $past(VOLTAGE_ANALOG_INPUT_I))
        else $error("voltage reference wrong");
    a_diff_clamp: assert property (
        uni && src_reg == 2'h3 && (neg ||
        $unsigned(VOLTAGE_ANALOG_INPUT_I) < CURRENT_LOOP_INPUT_I) |=>
        FREQ_REF_O == 12'h000)
        else $error("negative difference not clamped");
    a_bipolar_sign: assert property (
        bip && src_reg == 2'h0 |=> FREQ_REVERSE_O == $past(neg))
        else $error("bipolar direction wrong");
    a_loop_dir: assert property (
        bip && src_reg == 2'h1 |=> FREQ_REVERSE_O == $past(REVERSE_CMD_I))
        else $error("loop direction wrong");
endmodule : drive_input_monitor

bind drive_input_fault_select drive_input_monitor i_mon (
    .CORE_CLK_I, .SRST_I, .SETTINGS_LOAD_I, .EXT_FAULT_WINDOW_I,
    .MOTOR_OVERLOAD_MODE_I, .FREQ_SOURCE_SELECT_I, .FREQ_COMMAND_TERMINAL_I,
    .BIPOLAR_INPUT_ENABLE_I, .REVERSE_CMD_I, .RUNNING_I, .POWER_OFF_I,
    .VOLTAGE_ANALOG_INPUT_I, .CURRENT_LOOP_INPUT_I, .EXT_FAULT_DETECTED_O,
    .OVERLOAD_ENABLE_O, .OVERLOAD_CURVE_O, .THERMAL_ACCUM_O, .FREQ_REF_O,
    .FREQ_REVERSE_O);

// ---- sim/field_source.sv ----
`timescale 1ns/1ps
module field_source #(
    parameter int SETTLE_NS = 7
) (
    // asked for
    input wire logic [3:0] tw_i,
    input wire logic fl_i,
    input wire logic fw_i,
    input wire logic rv_i,
    // to the drive
    output logic [3:0] term_o,
    output logic flt_o,
    output logic fwd_o,
    output logic rev_o
);
    initial begin
        {term_o, flt_o, fwd_o} = 6'h00;
    end
    // terminal contacts bounce once; fault and forward contacts do not; all land off any clock edge
    always @(tw_i) begin
        #(SETTLE_NS);
        term_o = ~tw_i;
        #(SETTLE_NS);
        term_o = tw_i;
    end
    always @(fl_i or fw_i) begin
        #(SETTLE_NS);
        {flt_o, fwd_o} = {fl_i, fw_i};
    end
    // direction is the user's own switch, not the analog level
    assign rev_o = rv_i;
endmodule : field_source

// ---- sim/test_drive_input_fault_select.sv ----
`timescale 1ns/1ps
module test_drive_input_fault_select;
    typedef struct {string name; int sel; logic [15:0] exp;} note_t;
    note_t notes[$];
    event sample_ev;
    int fails = 0;
    int tests_run = 0;
    integer seed = 32'h0000_6b65;
    logic clk, srst, load, zsb, pol, win, bip, running, poff, tadd;
    logic fw, fl, rv, frev, zh, fd, oe, w2, ramp2, bb, serr, flt, fwd, rev;
    logic [1:0] resp, src, oc;
    logic [2:0] olm;
    logic [3:0] tw, term, fa, spd;
    logic [4:0] fcase [6] = '{5'h00, 5'h11, 5'h09, 5'h18, 5'h0f, 5'h0c};
    logic [5:0] fn [4];
    logic signed [11:0] vw;
    logic [11:0] lw, fref;
    logic tw3, jog;
    logic [7:0] hbc;
    logic [15:0] th;
    field_source i_field (.tw_i(tw), .fl_i(fl), .fw_i(fw), .rv_i(rv),
        .term_o(term), .flt_o(flt), .fwd_o(fwd), .rev_o(rev));
    drive_input_fault_select i_dut (.CORE_CLK_I(clk), .SRST_I(srst),
        .SETTINGS_LOAD_I(load), .ZERO_SPEED_BRAKE_ENABLE_I(zsb),
        .EXT_FAULT_POLARITY_I(pol), .EXT_FAULT_WINDOW_I(win),
        .EXT_FAULT_RESPONSE_I(resp), .MOTOR_OVERLOAD_MODE_I(olm),
        .FREQ_SOURCE_SELECT_I(src), .TERMINAL5_FUNCTION_I(fn[0]),
        .TERMINAL6_FUNCTION_I(fn[1]), .TERMINAL7_FUNCTION_I(fn[2]),
        .TERMINAL8_FUNCTION_I(fn[3]), .RUN_SOURCE_TERMINAL_I(1'b1),
        .FREQ_COMMAND_TERMINAL_I(1'b1), .BIPOLAR_INPUT_ENABLE_I(bip),
        .INPUT_SCAN_PERIOD_I(1'b0), .DC_BRAKE_CURRENT_I(8'h32),
        .TERMINAL_I(term), .EXT_FAULT_I(flt), .FORWARD_RUN_I(fwd),
        .REVERSE_CMD_I(rev), .RUNNING_I(running), .POWER_OFF_I(poff),
        .THERMAL_ADD_I(tadd), .VOLTAGE_ANALOG_INPUT_I(vw),
        .CURRENT_LOOP_INPUT_I(lw), .ZERO_SPEED_HOLD_O(zh),
        .HOLD_BRAKE_CURRENT_O(hbc), .EXT_FAULT_DETECTED_O(fd),
        .FAULT_ACTION_O(fa), .OVERLOAD_ENABLE_O(oe), .OVERLOAD_CURVE_O(oc),
        .THERMAL_ACCUM_O(th), .FREQ_REF_O(fref), .FREQ_REVERSE_O(frev),
        .THREE_WIRE_DIR_O(tw3), .TWO_WIRE_STOP_O(w2), .SPEED_SELECT_O(spd),
        .JOG_SELECT_O(jog), .SECOND_RAMP_O(ramp2), .BASEBLOCK_O(bb),
        .SETTING_ERROR_O(serr));
    function automatic logic [15:0] seen(input int s);
        case (s)
            0: return 16'(fref);
            1: return 16'(frev);
            2: return 16'(oe);
            3: return 16'(oc);
            4: return 16'(fd);
            5: return 16'(fa);
            6: return 16'(spd);
            7: return 16'(w2);
            8: return 16'(ramp2);
            9: return 16'(bb);
            10: return 16'(serr);
            11: return 16'(zh);
            12: return 16'({tw3, jog, hbc});
            default: return th;
        endcase
    endfunction : seen
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick
    task automatic note(input string n, input int s, input logic [15:0] e);
        notes.push_back('{n, s, e});
        -> sample_ev;
    endtask : note
    // bounded wait on a level, then compare it
    task automatic await(input string n, input int s, input logic [15:0] e,
            input int lim);
        for (int i = 0; i < lim && seen(s) !== e; i++) begin
            tick(1);
        end
        note(n, s, e);
    endtask : await
    task automatic pulse_load;
        load = 1'b1;
        tick(1);
        load = 1'b0;
        tick(2);
    endtask : pulse_load
    task automatic codes(input logic [5:0] a, b, c, d);
        fn = '{a, b, c, d};
        pulse_load();
    endtask : codes
    task automatic give_verdict;
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        note_t n;
        forever begin
            @(sample_ev);
            while (notes.size() > 0) begin
                n = notes.pop_front();
                tests_run++;
                if (seen(n.sel) !== n.exp) begin
                    fails++;
                    $display("MISMATCH %s expected %h seen %h", n.name,
                        n.exp, seen(n.sel));
                end
            end
        end
    end
    initial begin
        #(25 * 260000);
        fails++;
        give_verdict();
    end
    initial begin
        int e, v, f, d;
        {srst, load, zsb, pol, win, bip, running, poff, tadd} = 9'h100;
        {fw, fl, rv, resp, src, tw, vw, lw} = '0;
        olm = drive_input_pkg::OVERLOAD_RST;
        fn = '{6'h02, 6'h03, 6'h06, 6'h08};
        tick(4);
        srst = 1'b0;
        tick(2);
        note("overload_enable", 2, 16'h0001);
        note("setting_error", 10, 16'h0000);
        note("baseblock", 9, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            {pol, fl, win, running} = fcase[k][4:1];
            await("fault_detected", 4, 16'(fcase[k][0]), 12);
        end
        // one scan covers every terminal and fault check, so wait once
        {zsb, fw, tw, pol, fl} = 8'hdd;
        codes(6'h01, 6'h04, 6'h07, 6'h09);
        note("two_wire_stop", 7, 16'h0000);
        await("two_wire_stop", 7, 16'h0001, 205000);
        note("speed_select", 6, 16'h0004);
        note("second_ramp", 8, 16'h0001);
        note("baseblock", 9, 16'h0001);
        note("zero_hold", 11, 16'h0001);
        {zsb, fw} = 2'b00;
        codes(6'h00, 6'h06, 6'h08, 6'h10);
        note("three_jog_hold", 12,
            16'({2'b11, 8'(drive_input_pkg::HOLD_BRAKE_PCT)}));
        note("baseblock", 9, 16'h0001);
        codes(6'h07, 6'h06, 6'h08, 6'h09);
        note("setting_error", 10, 16'h0001);
        codes(6'h02, 6'h03, 6'h15, 6'h16);
        note("setting_error", 10, 16'h0001);
        codes(6'h01, 6'h04, 6'h07, 6'h09);
        codes(6'h3f, 6'h04, 6'h07, 6'h09);
        note("setting_error", 10, 16'h0000);
        for (int m = 0; m < 8; m++) begin
            olm = 3'(m);
            pulse_load();
            e = (m > 4) ? 4 : m;
            note("overload_enable", 2, 16'(e != 0));
            note("overload_curve", 3, 16'((e + 3) % 4));
        end
        await("fault_detected", 4, 16'h0001, 12);
        for (int r = 0; r < 4; r++) begin
            resp = 2'(r);
            pulse_load();
            note("fault_action", 5, 16'(1 << r));
        end
        for (int k = 2; k < 6; k++) begin
            {pol, fl, win, running} = fcase[k][4:1];
            await("fault_detected", 4, 16'(fcase[k][0]), 12);
        end
        tick(2);
        note("fault_action", 5, 16'h0000);
        {fl, win, running} = 3'b000;
        for (int k = 0; k < 6; k++) begin
            vw = 12'($random(seed));
            lw = 12'($random(seed));
            rv = 1'($random(seed));
            for (int s = 0; s < 8; s++) begin
                {bip, src} = 3'(s);
                pulse_load();
                v = (!bip && vw < 0) ? 0 : int'(vw);
                f = (src == 1 ? 0 : v) + (src == 0 ? 0 : int'(lw)) *
                    (src == 3 ? -1 : 1);
                f = (!bip && f < 0) ? 0 : f;
                d = (bip && src != 1) ? int'(f < 0) : int'(rv);
                f = (f < 0) ? -f : f;
                f = (f > 4095) ? 4095 : f;
                note("freq_ref", 0, 16'(f));
                note("freq_reverse", 1, 16'(d));
            end
        end
        tadd = 1'b1;
        tick(10);
        {tadd, poff} = 2'b01;
        tick(2);
        note("thermal", 13, 16'h0000);
        poff = 1'b0;
        tick(2);
        give_verdict();
    end
endmodule : test_drive_input_fault_select
